// ===== inc/adc_pkg.sv
// constants and types shared by the a/d conversion sequencer and its sar engine
package adc_pkg;

  localparam logic [7:0] OFS_CSR   = 8'h00;
  localparam logic [7:0] OFS_CR    = 8'h04;
  localparam logic [7:0] OFS_DATA0 = 8'h08;
  localparam logic [7:0] OFS_EVT   = 8'h18;
  localparam logic [7:0] OFS_MASK  = 8'h1c;

  localparam int CSR_FLAG   = 7;
  localparam int CSR_IE     = 6;
  localparam int CSR_GO     = 5;
  localparam int CSR_SCAN   = 4;
  localparam int CR_TRG_HI  = 7;
  localparam int CR_TRG_LO  = 6;
  localparam int CR_CKS_HI  = 3;
  localparam int CR_CKS_LO  = 2;

  localparam logic [1:0] CR_FIXED_ONES = 2'h3;
  localparam logic [7:0] CSR_RESET     = 8'h00;

  localparam int          RES_BITS  = 10;
  localparam int          RES_LSB   = 6;
  localparam int          N_SLOTS   = 4;
  localparam int          SAR_STEPS = 10;
  localparam logic [9:0]  SAR_FIRST = 10'h200;
  localparam logic [9:0]  RES_MAX   = 10'h3ff;

  localparam int N_EVT    = 3;
  localparam int EVT_DONE = 0;
  localparam int EVT_CHAN = 1;
  localparam int EVT_TRIG = 2;

  // all phase lengths are in states; one state is one pclk period
  localparam int STATE_NS      = 10;
  localparam int CLK_NS        = 10;
  localparam int CYC_PER_STATE = (STATE_NS + CLK_NS - 1) / CLK_NS;

  localparam int DLY_MIN_ST  [4] = '{18, 10, 6, 4};
  localparam int DLY_MAX_ST  [4] = '{33, 17, 9, 5};
  localparam int SAMP_ST     [4] = '{127, 63, 31, 15};
  localparam int CONV_MIN_ST [4] = '{515, 259, 131, 67};
  localparam int CONV_MAX_ST [4] = '{530, 266, 134, 68};
  localparam int SCAN_ST     [4] = '{512, 256, 128, 64};

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_DELAY  = 2'b01,
    PH_SAMPLE = 2'b11,
    PH_CONV   = 2'b10
  } phase_t;

  typedef enum logic [1:0] {
    TRG_SW    = 2'b00,
    TRG_TIMER = 2'b01,
    TRG_BAD   = 2'b10,
    TRG_EXT   = 2'b11
  } trig_src_t;

endpackage : adc_pkg

// ===== inc/sar_if.sv
// signals between the conversion sequencer and the successive-approximation register
`timescale 1ns/1ps
interface sar_if;
  logic                         start;
  logic                         step;
  logic                         cmp;
  logic                         busy;
  logic [adc_pkg::RES_BITS-1:0] trial;
  logic [adc_pkg::RES_BITS-1:0] result;

  modport engine (input start, step, cmp, output busy, trial, result);
  modport seq    (output start, step, cmp, input busy, trial, result);
endinterface : sar_if

// ===== rtl/adc_seq.sv
// a/d conversion sequencer: apb registers, start sources, phase timing, interrupts
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module adc_seq
  import adc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output wire logic [31:0]         prdata,
  output wire logic                pready,
  output wire logic                pslverr,
  input  wire logic                ext_trigger_pin,
  input  wire logic                timer_trig,
  input  wire logic                sar_cmp,
  output wire logic [RES_BITS-1:0] sar_trial,
  output wire logic                sample_hold,
  output wire logic [3:0]          chan_sel,
  output wire logic                conv_done_irq,
  output wire logic                dma_req,
  output wire logic                irq
);

  sar_if sar ();

  sar_engine u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .s       (sar)
  );

  logic                flag_q;
  logic                ie_q;
  logic                go_q;
  logic                scan_q;
  logic [3:0]          ch_q;
  trig_src_t           trg_q;
  logic [1:0]          cks_q;
  logic                armed_q;
  logic [RES_BITS-1:0] data_q [N_SLOTS];
  logic [N_EVT-1:0]    evt_q;
  logic [N_EVT-1:0]    mask_q;
  logic [N_EVT-1:0]    evt_set;
  logic [31:0]         prdata_q;
  logic [31:0]         rd_d;
  logic [4:0]          presc_q;
  phase_t              phase_q;
  logic [9:0]          cnt_q;
  logic [1:0]          cur_q;
  logic                first_q;
  logic                trg_s1_q;
  logic                trg_s2_q;
  logic                trg_s3_q;
  logic                trg_lvl_q;
  logic                trg_lvl_d;
  logic                trig_fall;

  function automatic logic [9:0] cyc(input int st);
    return 10'(st * CYC_PER_STATE);
  endfunction : cyc

  function automatic logic is_data(input logic [7:0] a);
    return (a >= OFS_DATA0) && (a < OFS_DATA0 + 8'(4 * N_SLOTS)) && (a[1:0] == 2'h0);
  endfunction : is_data

  function automatic logic [1:0] slot_of(input logic [7:0] a);
    return 2'((a - OFS_DATA0) >> 2);
  endfunction : slot_of

  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CSR) || (a == OFS_CR) || (a == OFS_EVT) || (a == OFS_MASK) || is_data(a);
  endfunction : mapped

  // apb slave: zero wait states unless the clock enable is low
  logic setup;
  logic access;
  logic wr;
  logic wr_csr;
  logic rd_csr;
  logic rd_evt;

  assign setup   = psel & ~penable & ce;
  assign access  = psel & penable & ce;
  assign wr      = access & pwrite;
  assign wr_csr  = wr & (paddr == OFS_CSR);
  assign rd_csr  = access & ~pwrite & (paddr == OFS_CSR);
  assign rd_evt  = access & ~pwrite & (paddr == OFS_EVT);
  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata  = prdata_q;

  always_comb begin
    rd_d = '0;
    if (paddr == OFS_CSR) begin
      rd_d[7:0] = {flag_q, ie_q, go_q, scan_q, ch_q};
    end else if (paddr == OFS_CR) begin
      rd_d[7:0] = {trg_q, 2'h0, cks_q, CR_FIXED_ONES};
    end else if (is_data(paddr)) begin
      rd_d[15:0] = {data_q[slot_of(paddr)], {RES_LSB{1'b0}}};
    end else if (paddr == OFS_EVT) begin
      rd_d[N_EVT-1:0] = evt_q;
    end else if (paddr == OFS_MASK) begin
      rd_d[N_EVT-1:0] = mask_q;
    end
  end

  // read data is frozen in the setup cycle so read-to-clear acts on exactly what was returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // trigger pin: three flops, level accepted once the last two agree
  assign trg_lvl_d = (trg_s2_q == trg_s3_q) ? trg_s3_q : trg_lvl_q;
  assign trig_fall = ce & trg_lvl_q & ~trg_lvl_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_s1_q  <= 1'b1;
      trg_s2_q  <= 1'b1;
      trg_s3_q  <= 1'b1;
      trg_lvl_q <= 1'b1;
    end else if (ce) begin
      trg_s1_q  <= ext_trigger_pin;
      trg_s2_q  <= trg_s1_q;
      trg_s3_q  <= trg_s2_q;
      trg_lvl_q <= trg_lvl_d;
    end
  end

  logic ext_go;
  logic tmr_go;
  logic sw_go;
  logic sw_stop;
  logic go_start;
  logic chan_end;
  logic last_ch;
  logic run_end;
  logic [1:0] slot;

  assign ext_go   = trig_fall & (trg_q == TRG_EXT);
  assign tmr_go   = ce & timer_trig & (trg_q == TRG_TIMER);
  assign sw_go    = wr_csr & pwdata[CSR_GO];
  assign sw_stop  = wr_csr & ~pwdata[CSR_GO];
  // every source merges into the same start, so a pin start runs exactly as a written one
  assign go_start = ~go_q & (sw_go | ext_go | tmr_go);
  assign chan_end = ce & go_q & (phase_q == PH_CONV) & (cnt_q == 10'h000);
  assign last_ch  = ~scan_q | (cur_q == ch_q[1:0]);
  assign run_end  = chan_end & last_ch;
  assign slot     = scan_q ? cur_q : ch_q[1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q   <= CSR_RESET[CSR_IE];
      scan_q <= CSR_RESET[CSR_SCAN];
      ch_q   <= CSR_RESET[3:0];
      go_q   <= CSR_RESET[CSR_GO];
    end else if (ce) begin
      if (wr_csr) begin
        ie_q   <= pwdata[CSR_IE];
        scan_q <= pwdata[CSR_SCAN];
        ch_q   <= pwdata[3:0];
      end
      if (go_start) begin
        go_q <= 1'b1;
      end else if (sw_stop || (chan_end && !scan_q)) begin
        go_q <= 1'b0;
      end
    end
  end

  // done flag: a completion in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q  <= CSR_RESET[CSR_FLAG];
      armed_q <= 1'b0;
    end else if (ce) begin
      if (run_end) begin
        flag_q <= 1'b1;
      end else if (wr_csr && !pwdata[CSR_FLAG] && armed_q) begin
        flag_q <= 1'b0;
      end
      if (rd_csr && prdata_q[CSR_FLAG]) begin
        armed_q <= 1'b1;
      end else if (wr_csr) begin
        armed_q <= 1'b0;
      end
    end
  end

  // source and clock select are meant to change only while stopped; no interlock is built in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_q  <= TRG_SW;
      cks_q  <= 2'h0;
      mask_q <= '0;
    end else if (ce) begin
      if (wr && paddr == OFS_CR) begin
        trg_q <= trig_src_t'(pwdata[CR_TRG_HI:CR_TRG_LO]);
        cks_q <= pwdata[CR_CKS_HI:CR_CKS_LO];
      end
      if (wr && paddr == OFS_MASK) begin
        mask_q <= pwdata[N_EVT-1:0];
      end
    end
  end

  always_comb begin
    evt_set           = '0;
    evt_set[EVT_DONE] = run_end;
    evt_set[EVT_CHAN] = chan_end;
    evt_set[EVT_TRIG] = ext_go & ~go_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= '0;
    end else if (ce) begin
      evt_q <= (rd_evt ? (evt_q & ~prdata_q[N_EVT-1:0]) : evt_q) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_SLOTS; i++) begin
        data_q[i] <= '0;
      end
    end else if (chan_end) begin
      data_q[slot] <= sar.result;
    end
  end

  // free-running phase counter: the start delay depends on where the start lands in it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else if (ce) begin
      presc_q <= presc_q + 5'h01;
    end
  end

  logic [9:0] delay_cyc;
  logic [9:0] samp_cyc;
  logic [9:0] sar_cyc;
  logic [9:0] fill_cyc;

  assign delay_cyc = cyc(DLY_MIN_ST[cks_q])
                   + (10'(presc_q) & (cyc(DLY_MAX_ST[cks_q] - DLY_MIN_ST[cks_q] + 1) - 10'h001));
  assign samp_cyc  = cyc(SAMP_ST[cks_q]);
  assign sar_cyc   = cyc(CONV_MIN_ST[cks_q] - DLY_MIN_ST[cks_q] - SAMP_ST[cks_q]);
  assign fill_cyc  = cyc(SCAN_ST[cks_q]) - samp_cyc - sar_cyc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_IDLE;
      cnt_q   <= '0;
      cur_q   <= '0;
      first_q <= 1'b0;
    end else if (ce) begin
      if (go_start) begin
        phase_q <= PH_DELAY;
        cnt_q   <= delay_cyc - 10'h001;
        cur_q   <= '0;
        first_q <= 1'b1;
      end else if (!go_q || sw_stop) begin
        phase_q <= PH_IDLE;
        cnt_q   <= '0;
      end else if (cnt_q != 10'h000) begin
        cnt_q <= cnt_q - 10'h001;
      end else begin
        unique case (phase_q)
          PH_IDLE: begin
            cnt_q <= '0;
          end
          PH_DELAY: begin
            phase_q <= PH_SAMPLE;
            cnt_q   <= samp_cyc - 10'h001;
          end
          PH_SAMPLE: begin
            phase_q <= PH_CONV;
            cnt_q   <= sar_cyc - 10'h001;
          end
          PH_CONV: begin
            if (scan_q) begin
              phase_q <= PH_DELAY;
              cnt_q   <= fill_cyc - 10'h001;
              cur_q   <= last_ch ? 2'h0 : cur_q + 2'h1;
              first_q <= 1'b0;
            end else begin
              phase_q <= PH_IDLE;
            end
          end
        endcase
      end
    end
  end

  // the sar decides its ten bits in the last cycles of the conversion phase
  assign sar.start = ce & go_q & (phase_q == PH_SAMPLE) & (cnt_q == 10'h000);
  assign sar.step  = ce & (phase_q == PH_CONV) & (cnt_q != 10'h000) & (cnt_q <= 10'(SAR_STEPS));
  assign sar.cmp   = sar_cmp;

  assign sar_trial     = sar.trial;
  assign sample_hold   = (phase_q == PH_SAMPLE);
  assign chan_sel      = scan_q ? {2'h0, cur_q} : ch_q;
  assign conv_done_irq = flag_q & ie_q;
  assign dma_req       = flag_q;
  assign irq           = |(evt_q & mask_q);

  // checking helper: cycles since the current conversion began
  logic [9:0] seg_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_q <= '0;
    end else if (go_start || chan_end) begin
      seg_q <= '0;
    end else if (ce && go_q) begin
      seg_q <= seg_q + 10'h001;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start;
    ce && !go_q && (sw_go || ext_go || tmr_go);
  endsequence

  sequence s_sample_ends;
    ce && go_q && !sw_stop && phase_q == PH_SAMPLE && cnt_q == 10'h000;
  endsequence

  a_sample_after_delay: assert property ($rose(sample_hold) |-> $past(phase_q) == PH_DELAY)
    else $error("sampling began without start delay");

  a_conv_after_sample: assert property (s_sample_ends |=> phase_q == PH_CONV && sar.busy)
    else $error("conversion did not follow sampling");

  a_delay_range: assert property (s_start |=>
    cnt_q >= cyc(DLY_MIN_ST[$past(cks_q)]) - 10'h001 && cnt_q <= cyc(DLY_MAX_ST[$past(cks_q)]) - 10'h001)
    else $error("start delay outside its range");

  a_sample_length: assert property ($rose(sample_hold) |-> cnt_q == cyc(SAMP_ST[cks_q]) - 10'h001)
    else $error("sampling window has wrong length");

  a_first_conv_time: assert property (chan_end && first_q |->
    seg_q + 10'h001 >= cyc(CONV_MIN_ST[cks_q]) && seg_q + 10'h001 <= cyc(CONV_MAX_ST[cks_q]))
    else $error("first conversion time outside its range");

  a_scan_fixed_time: assert property (chan_end && !first_q |-> seg_q + 10'h001 == cyc(SCAN_ST[cks_q]))
    else $error("scan conversion time not fixed");

  a_pin_ignored: assert property (trig_fall && trg_q != TRG_EXT && !go_q && !wr_csr && !tmr_go |=> !go_q)
    else $error("trigger pin started a conversion while not selected");

  a_pin_starts: assert property (ext_go && !go_q |=> go_q && phase_q == PH_DELAY)
    else $error("trigger edge did not start a conversion");

  a_done_irq: assert property (run_end && ie_q && !wr_csr |=> conv_done_irq && dma_req)
    else $error("done interrupt not raised");

  a_result_kept: assert property (chan_end |=> data_q[$past(slot)] == $past(sar.result))
    else $error("result not stored");

  a_single_stops: assert property (chan_end && !scan_q |=> !go_q && phase_q == PH_IDLE)
    else $error("single conversion did not clear go");

  a_flag_sets: assert property (run_end |=> flag_q)
    else $error("done flag not set at end");

  a_scan_wraps: assert property (chan_end && scan_q && last_ch && !sw_stop |=>
    go_q && cur_q == 2'h0 && phase_q == PH_DELAY)
    else $error("scan did not restart at first channel");

  a_stop_aborts: assert property (sw_stop && go_q |=> !go_q && phase_q == PH_IDLE && cnt_q == 10'h000)
    else $error("clearing go did not abort");

endmodule : adc_seq

// ===== rtl/sar_engine.sv
// successive-approximation register, one bit decided per step
`timescale 1ns/1ps
module sar_engine
  import adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  sar_if.engine    s
);

  logic [RES_BITS-1:0] trial_q;
  logic [RES_BITS-1:0] mask_q;
  logic [RES_BITS-1:0] res_q;
  logic [RES_BITS-1:0] kept;
  logic                busy_q;

  // comparator high means the input is at or above the trial code
  assign kept = s.cmp ? trial_q : (trial_q & ~mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial_q <= '0;
      mask_q  <= '0;
      res_q   <= '0;
      busy_q  <= 1'b0;
    end else if (ce) begin
      if (s.start) begin
        trial_q <= SAR_FIRST;
        mask_q  <= SAR_FIRST;
        busy_q  <= 1'b1;
      end else if (s.step && busy_q) begin
        trial_q <= kept | (mask_q >> 1);
        mask_q  <= mask_q >> 1;
        if (mask_q[0]) begin
          res_q  <= kept;
          busy_q <= 1'b0;
        end
      end
    end
  end

  assign s.trial  = trial_q;
  assign s.result = res_q;
  assign s.busy   = busy_q;

  a_sar_last_bit: assert property (@(posedge pclk) disable iff (!presetn)
    ce && s.step && busy_q && mask_q[0] && !s.start |=> !busy_q && res_q == $past(kept))
    else $error("sar result not taken on last step");

endmodule : sar_engine

// ===== sim/adc_seq_tb_top.sv
// self-checking bench for the a/d conversion sequencer
`timescale 1ns/1ps
module adc_seq_tb_top import adc_pkg::*;;
  localparam logic [9:0] LEVEL [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_trigger_pin;
  logic        timer_trig;
  logic        sar_cmp;
  logic [9:0]  sar_trial;
  logic        sample_hold;
  logic [3:0]  chan_sel;
  logic        conv_done_irq;
  logic        dma_req;
  logic        irq;
  logic        fire;
  logic [31:0] v;
  logic        e;
  int          n_mismatch;
  int          tests_run;

  adc_seq uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trigger_pin(ext_trigger_pin), .timer_trig(timer_trig), .sar_cmp(sar_cmp), .sar_trial(sar_trial),
    .sample_hold(sample_hold), .chan_sel(chan_sel), .conv_done_irq(conv_done_irq), .dma_req(dma_req), .irq(irq));

  analog_src #(.LEVEL(LEVEL)) far (.pclk(pclk), .chan_sel(chan_sel), .sar_trial(sar_trial), .fire(fire),
    .sar_cmp(sar_cmp), .ext_trigger_pin(ext_trigger_pin));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; an idle edge follows so the next setup never reassigns psel in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(v, exp);
  endtask : rdc

  task automatic run_single(input logic [1:0] cks, input logic [3:0] ch, input logic ie);
    int n;
    int d;
    int sh;
    wr(OFS_MASK, {31'h0, ie});
    wr(OFS_CR, {24'h0, 4'h0, cks, 2'h3});
    wr(OFS_CSR, {24'h0, 1'b0, ie, 2'b10, ch});
    n = 1;
    d = 0;
    sh = 0;
    while (dma_req !== 1'b1 && n < 700) begin
      @(posedge pclk);
      #1;
      n++;
      if (sample_hold === 1'b1) begin
        sh++;
        if (d == 0) d = n;
      end
    end
    chk(d >= DLY_MIN_ST[cks] && d <= DLY_MAX_ST[cks], 1);
    chk(sh, SAMP_ST[cks]);
    chk(n >= CONV_MIN_ST[cks] && n <= CONV_MAX_ST[cks], 1);
    chk(conv_done_irq, ie);
    chk(irq, ie);
    apb(1'b0, OFS_EVT, 32'h0);
    chk(v[EVT_DONE], 1'b1);
    chk(irq, 1'b0);
    rdc(OFS_DATA0 + {4'h0, ch[1:0], 2'b00}, {16'h0, LEVEL[ch[1:0]], 6'h0});
    rdc(OFS_CSR, {24'h0, 1'b1, ie, 2'b00, ch});
    wr(OFS_CSR, {24'h0, 1'b0, ie, 2'b00, ch});
    chk(dma_req, 1'b0);
  endtask : run_single

  task automatic tally_and_finish;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #500us;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    int n;
    int k;
    int t [8];
    logic [3:0] cs [8];
    logic [3:0] prev;
    n_mismatch = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, timer_trig, fire} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFS_CSR, {24'h0, CSR_RESET});
    rdc(OFS_CR, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    wr(OFS_CR, 32'hff);
    rdc(OFS_CR, 32'hcf);
    $display("test registers done");
    for (int c = 0; c < 4; c++) run_single(c[1:0], 4'(c), c[0]);
    $display("test single done");
    // scan over slots 0..3 at the fastest clock select
    wr(OFS_CR, 32'h0f);
    wr(OFS_CSR, 32'h33);
    n = 1;
    k = 0;
    prev = chan_sel;
    repeat (300) begin
      @(posedge pclk);
      #1;
      n++;
      if (chan_sel !== prev && k < 8) begin
        t[k] = n;
        cs[k] = chan_sel;
        k++;
        prev = chan_sel;
      end
    end
    chk(k, 4);
    chk(t[0] >= CONV_MIN_ST[3] && t[0] <= CONV_MAX_ST[3], 1);
    for (int i = 1; i < 4; i++) chk(t[i] - t[i-1], SCAN_ST[3]);
    chk({cs[0], cs[1], cs[2], cs[3]}, 16'h1230);
    chk(dma_req, 1'b1);
    for (int s = 0; s < 4; s++) rdc(OFS_DATA0 + 8'(4 * s), {16'h0, LEVEL[s], 6'h0});
    wr(OFS_CSR, 32'h10);
    k = 0;
    repeat (100) begin
      @(posedge pclk);
      if (sample_hold === 1'b1) k++;
    end
    chk(k, 0);
    rdc(OFS_CSR, 32'h90);
    wr(OFS_CSR, 32'h0);
    $display("test scan done");
    // each start source with both pin and timer fired
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CR, {24'h0, s[1:0], 6'h0f});
      wr(OFS_CSR, 32'h01);
      fire <= 1'b1;
      timer_trig <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      timer_trig <= 1'b0;
      repeat (10) @(posedge pclk);
      apb(1'b0, OFS_CSR, 32'h0);
      chk(v[CSR_GO], s == 1 || s == 3);
      apb(1'b0, OFS_EVT, 32'h0);
      chk(v[EVT_TRIG], s == 3);
      n = 0;
      while (dma_req !== 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      chk(dma_req, s == 1 || s == 3);
      if (s == 3) rdc(OFS_DATA0 + 8'h4, {16'h0, LEVEL[1], 6'h0});
      apb(1'b0, OFS_CSR, 32'h0);
      wr(OFS_CSR, 32'h0);
    end
    $display("test trigger done");
    // software abort in mid-delay never completes
    wr(OFS_CR, 32'h03);
    wr(OFS_CSR, 32'h20);
    repeat (5) @(posedge pclk);
    wr(OFS_CSR, 32'h0);
    repeat (600) @(posedge pclk);
    chk({dma_req, sample_hold}, 2'b00);
    rdc(OFS_CSR, 32'h0);
    $display("test abort done");
    tally_and_finish();
  end
endmodule : adc_seq_tb_top

// ===== sim/analog_src.sv
// behavioural analog inputs and external trigger source facing the sequencer
`timescale 1ns/1ps
module analog_src #(
  parameter logic [9:0] LEVEL [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa}
) (
  input  wire logic       pclk,
  input  wire logic [3:0] chan_sel,
  input  wire logic [9:0] sar_trial,
  input  wire logic       fire,
  output wire logic       sar_cmp,
  output wire logic       ext_trigger_pin
);
  logic [3:0] low_q = 4'h0;

  // comparator settles within the cycle; one fixed level per slot
  assign sar_cmp = (LEVEL[chan_sel[1:0]] >= sar_trial);

  // pin idles high; a request holds it low long enough to pass the pin filter
  always_ff @(posedge pclk) begin
    if (fire) begin
      low_q <= 4'h8;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
  end
  assign ext_trigger_pin = (low_q == 4'h0);
endmodule : analog_src
